//--- hdl/bssc_params.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * backup supply switch control block.
 * Assumes inclusion by bare name from bssc_top; the package does not include it.
 */
`ifndef BSSC_PARAMS_SVH
`define BSSC_PARAMS_SVH

// Register indices; byte address is four times the index
`define BSSC_IDX_TIME_LAST  8'h06
`define BSSC_IDX_OUT_CTRL   8'h07
`define BSSC_IDX_MODE_CTRL  8'h08
`define BSSC_IDX_STATUS     8'h0B
`define BSSC_IDX_IRQ_STAT   8'h20
`define BSSC_IDX_IRQ_MASK   8'h21

// Output control fields
`define BSSC_OUT_LEVEL_BIT  7
`define BSSC_OUT_FSEL_BIT   6
`define BSSC_OUT_CTRL_RST   8'h80

// Mode control fields
`define BSSC_MODE_ALMEN_BIT 6
`define BSSC_MODE_DSEL_BIT  5

// Status fields
`define BSSC_ST_REARM_BIT   5
`define BSSC_ST_ALARM_BIT   2
`define BSSC_ST_BAT_BIT     1
`define BSSC_ST_LOSS_BIT    0

// Interrupt status fields
`define BSSC_IRQ_ALARM_BIT  0
`define BSSC_IRQ_TOBAT_BIT  1
`define BSSC_IRQ_TOMAIN_BIT 2
`define BSSC_IRQ_W          3

// Timing: 512 Hz output from the 250 MHz clock
`define BSSC_CLK_HZ         250000000
`define BSSC_FOUT_HZ        512
`define BSSC_HALF_CYC       (`BSSC_CLK_HZ / (2 * `BSSC_FOUT_HZ))

`endif

//--- hdl/bssc_pkg.sv
/*
 * Types of the backup supply switch control block.
 * Assumes bssc_params.svh is on the include path.
 */
package bssc_pkg;

	// Supply selection states
	typedef enum logic [1:0] {
		BSSC_SEALED  = 2'b00,
		BSSC_MAIN    = 2'b01,
		BSSC_BATTERY = 2'b10
	} bssc_supply_t;

endpackage

//--- hdl/bssc_sync.sv
/*
 * Two-flop synchroniser bank, one chain per bit.
 * Assumes inputs are levels that stay put for several clocks.
 */
`timescale 1ns/10ps
module bssc_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);

	// ****************************************
	// Per-bit chains
	// ****************************************
	logic [W-1:0] meta;  // First stage, read by second stage only

	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			// Two flops per bit
			always_ff @(posedge i_clk) begin
				if (i_rst) begin
					meta[g]   <= 1'b0;
					o_sync[g] <= 1'b0;
				end else begin
					meta[g]   <= i_async[g];
					o_sync[g] <= meta[g];
				end
			end
		end
	endgenerate

endmodule

//--- hdl/bssc_div.sv
/*
 * Enable-pulse divider: one pulse every HALF clock cycles.
 * Assumes a single clock; the pulse toggles the output square wave.
 */
`timescale 1ns/10ps
module bssc_div #(
	parameter int HALF = 4
) (
	input  wire logic i_clk,
	input  wire logic i_rst,
	output logic      o_tick
);

	// ****************************************
	// Counter
	// ****************************************
	logic [31:0] cnt;       // Cycles since last pulse
	logic [31:0] next_cnt;
	logic        next_tick;

	// Wrap at HALF-1 and pulse once
	always_comb begin
		next_tick = 1'b0;
		next_cnt  = cnt + 32'h0000_0001;
		if (cnt >= 32'(HALF - 1)) begin
			next_cnt  = 32'h0000_0000;
			next_tick = 1'b1;
		end
	end

	// Register counter and pulse
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt    <= 32'h0000_0000;
			o_tick <= 1'b0;
		end else begin
			cnt    <= next_cnt;
			o_tick <= next_tick;
		end
	end

endmodule

//--- hdl/bssc_top.sv
/*
 * Backup supply switch control: supply selection with hysteresis,
 * direct-switch mode, battery seal and re-arm, total power loss flag,
 * serial pin gating, dual-function open-drain output, APB registers
 * and a level interrupt.
 * Assumes comparator outputs are asynchronous levels, the serial
 * engine asks for SDA pull-down on i_sda_pull, and one 250 MHz clock.
 */
`timescale 1ns/10ps
`include "bssc_params.svh"

module bssc_top #(
	parameter int FOUT_HALF = `BSSC_HALF_CYC
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [9:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire logic        i_main_present,
	input  wire logic        i_below_bat_minus_hys,
	input  wire logic        i_below_trip,
	input  wire logic        i_above_bat_plus_hys,
	input  wire logic        i_above_trip_plus_hys,
	input  wire logic        i_below_bat,
	input  wire logic        i_alarm_match,
	input  wire logic        i_total_loss,
	input  wire logic        i_sda_pull,
	output logic             o_sda_o,
	output logic             o_sda_oe,
	output logic             o_serial_en,
	output logic             o_fout_o,
	output logic             o_fout_oe,
	output logic             o_on_battery,
	output logic             o_bat_draw_en,
	output logic             o_trip_mon_en,
	output logic             o_time_run,
	output logic             o_irq
);
	import bssc_pkg::*;

	// ****************************************
	// Synchronised comparator levels
	// ****************************************
	logic [5:0] cmp;  // {below_bat, above_trip+h, above_bat+h,
	                  //  below_trip, below_bat-h, main_present}

	bssc_sync #(.W(6)) u_sync (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_async ({i_below_bat, i_above_trip_plus_hys,
		           i_above_bat_plus_hys, i_below_trip,
		           i_below_bat_minus_hys, i_main_present}),
		.o_sync  (cmp)
	);

	logic tick;  // Half period of the 512 Hz output

	bssc_div #(.HALF(FOUT_HALF)) u_div (
		.i_clk  (i_clk),
		.i_rst  (i_rst),
		.o_tick (tick)
	);

	// ****************************************
	// State
	// ****************************************
	bssc_supply_t            state, next_state;  // Supply selection
	logic                    main_q, next_main_q; // Last main level
	logic [7:0]              out_ctrl, next_out_ctrl;
	logic                    alm_en, next_alm_en;
	logic                    dsel, next_dsel;   // Direct switch
	logic                    alarm, next_alarm; // Sticky alarm
	logic                    loss, next_loss;   // Total loss flag
	logic                    hold, next_hold;   // Time counters held
	logic                    first, next_first; // First cycle out of reset
	logic [`BSSC_IRQ_W-1:0]  ists, next_ists;
	logic [`BSSC_IRQ_W-1:0]  imsk, next_imsk;
	logic                    sq, next_sq;       // 512 Hz square
	logic [31:0]             next_prdata;
	logic                    next_pready, next_pslverr;
	logic                    next_sda_oe, next_fout_oe;

	// ****************************************
	// Bus decode
	// ****************************************
	logic       acc, wr_en;
	logic [7:0] idx;
	logic       hit;
	logic [31:0] rd;

	// Access completes on the edge where pready is seen high
	assign acc   = i_psel & i_penable & o_pready;
	assign wr_en = acc & i_pwrite;
	assign idx   = i_paddr[9:2];

	// Read mux and map check
	always_comb begin
		rd  = 32'h0000_0000;
		hit = 1'b1;
		if (idx <= `BSSC_IDX_TIME_LAST) begin
			rd = 32'h0000_0000;
		end else if (idx == `BSSC_IDX_OUT_CTRL) begin
			rd[7:0] = out_ctrl;
		end else if (idx == `BSSC_IDX_MODE_CTRL) begin
			rd[`BSSC_MODE_ALMEN_BIT] = alm_en;
			rd[`BSSC_MODE_DSEL_BIT]  = dsel;
		end else if (idx == `BSSC_IDX_STATUS) begin
			rd[`BSSC_ST_ALARM_BIT] = alarm;
			rd[`BSSC_ST_BAT_BIT]   = (state == BSSC_BATTERY);
			rd[`BSSC_ST_LOSS_BIT]  = loss;
		end else if (idx == `BSSC_IDX_IRQ_STAT) begin
			rd[`BSSC_IRQ_W-1:0] = ists;
		end else if (idx == `BSSC_IDX_IRQ_MASK) begin
			rd[`BSSC_IRQ_W-1:0] = imsk;
		end else begin
			hit = 1'b0;
		end
	end

	// ****************************************
	// Next-state logic
	// ****************************************
	logic go_bat, go_main, rearm, main_rise;

	always_comb begin
		next_state    = state;
		next_main_q   = cmp[0];
		next_out_ctrl = out_ctrl;
		next_alm_en   = alm_en;
		next_dsel     = dsel;
		next_alarm    = alarm;
		next_loss     = loss;
		next_hold     = hold;
		next_first    = 1'b0;
		next_ists     = ists;
		next_imsk     = imsk;
		next_sq       = sq;
		main_rise     = cmp[0] & ~main_q;
		rearm = wr_en & (idx == `BSSC_IDX_STATUS) &
		        i_pwdata[`BSSC_ST_REARM_BIT];
		go_bat  = dsel ? cmp[5] : (cmp[1] & cmp[2]);
		go_main = dsel ? cmp[3] : (cmp[3] | cmp[4]);

		// supply state moves on synced comparator values and the re-arm write
		case (state)
			BSSC_SEALED: begin
				if (main_rise) begin
					next_state = BSSC_MAIN;
				end
			end
			BSSC_MAIN: begin
				if (rearm) begin
					next_state = BSSC_SEALED;
				end else if (go_bat) begin
					next_state = BSSC_BATTERY;
				end
			end
			BSSC_BATTERY: begin
				if (go_main) begin
					next_state = BSSC_MAIN;
				end
			end
			default: begin
				next_state = BSSC_SEALED;
			end
		endcase

		// Register writes; clears first, hardware sets after
		if (wr_en) begin
			if (idx <= `BSSC_IDX_TIME_LAST) begin
				next_hold = 1'b0;
			end else if (idx == `BSSC_IDX_OUT_CTRL) begin
				next_out_ctrl = i_pwdata[7:0];
			end else if (idx == `BSSC_IDX_MODE_CTRL) begin
				next_alm_en = i_pwdata[`BSSC_MODE_ALMEN_BIT];
				next_dsel   = i_pwdata[`BSSC_MODE_DSEL_BIT];
			end else if (idx == `BSSC_IDX_STATUS) begin
				if (i_pwdata[`BSSC_ST_ALARM_BIT]) begin
					next_alarm = 1'b0;
				end
				if (i_pwdata[`BSSC_ST_LOSS_BIT]) begin
					next_loss = 1'b0;
				end
			end else if (idx == `BSSC_IDX_IRQ_STAT) begin
				next_ists = ists & ~i_pwdata[`BSSC_IRQ_W-1:0];
			end else if (idx == `BSSC_IDX_IRQ_MASK) begin
				next_imsk = i_pwdata[`BSSC_IRQ_W-1:0];
			end
		end

		// strap caught once after reset release
		if (first && i_total_loss) begin
			next_loss = 1'b1;
			next_hold = 1'b1;
		end
		// alarm match latched, set beats clear
		if (i_alarm_match && alm_en) begin
			next_alarm = 1'b1;
		end
		if (i_alarm_match && alm_en && !alarm) begin
			next_ists[`BSSC_IRQ_ALARM_BIT] = 1'b1;
		end
		if (state == BSSC_MAIN && next_state == BSSC_BATTERY) begin
			next_ists[`BSSC_IRQ_TOBAT_BIT] = 1'b1;
		end
		if (state == BSSC_BATTERY && next_state == BSSC_MAIN) begin
			next_ists[`BSSC_IRQ_TOMAIN_BIT] = 1'b1;
		end

		// square wave toggles on each tick, twice per 512 Hz period
		if (tick) begin
			next_sq = ~sq;
		end
	end

	// ****************************************
	// Pin and bus outputs
	// ****************************************
	always_comb begin
		next_sda_oe = i_sda_pull & (next_state == BSSC_MAIN);
		// drive low only, pull-up gives high
		if (next_out_ctrl[`BSSC_OUT_FSEL_BIT]) begin
			next_fout_oe = ~next_sq;
		end else begin
			next_fout_oe = ~next_out_ctrl[`BSSC_OUT_LEVEL_BIT];
		end
		// One wait state: pready follows the access phase
		next_pready  = i_psel & i_penable & ~o_pready;
		next_pslverr = next_pready & ~hit;
		next_prdata  = o_prdata;
		if (next_pready && !i_pwrite) begin
			next_prdata = rd;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	// Power-on reset puts the block sealed with defaults
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state         <= BSSC_SEALED;
			main_q        <= 1'b0;
			out_ctrl      <= `BSSC_OUT_CTRL_RST;
			alm_en        <= 1'b0;
			dsel          <= 1'b0;
			alarm         <= 1'b0;
			loss          <= 1'b0;
			hold          <= 1'b0;
			first         <= 1'b1;
			ists          <= '0;
			imsk          <= '0;
			sq            <= 1'b0;
			o_prdata      <= 32'h0000_0000;
			o_pready      <= 1'b0;
			o_pslverr     <= 1'b0;
			o_sda_o       <= 1'b0;
			o_sda_oe      <= 1'b0;
			o_serial_en   <= 1'b0;
			o_fout_o      <= 1'b0;
			o_fout_oe     <= 1'b0;
			o_on_battery  <= 1'b0;
			o_bat_draw_en <= 1'b0;
			o_trip_mon_en <= 1'b1;
			o_time_run    <= 1'b1;
			o_irq         <= 1'b0;
		end else begin
			state         <= next_state;
			main_q        <= next_main_q;
			out_ctrl      <= next_out_ctrl;
			alm_en        <= next_alm_en;
			dsel          <= next_dsel;
			alarm         <= next_alarm;
			loss          <= next_loss;
			hold          <= next_hold;
			first         <= next_first;
			ists          <= next_ists;
			imsk          <= next_imsk;
			sq            <= next_sq;
			o_prdata      <= next_prdata;
			o_pready      <= next_pready;
			o_pslverr     <= next_pslverr;
			o_sda_o       <= 1'b0;
			o_sda_oe      <= next_sda_oe;
			// serial engine enabled on main only
			o_serial_en   <= (next_state == BSSC_MAIN);
			o_fout_o      <= 1'b0;
			o_fout_oe     <= next_fout_oe;
			o_on_battery  <= (next_state == BSSC_BATTERY);
			o_bat_draw_en <= (next_state != BSSC_SEALED);
			// trip monitor powered down in direct mode
			o_trip_mon_en <= ~next_dsel;
			o_time_run    <= ~next_hold;
			o_irq         <= |(next_ists & next_imsk);
		end
	end

endmodule

//--- tb/bssc_monitor.sv
/* Checker for bssc_top, port-level relations only.
   Assumes binding onto bssc_top and held comparator levels. */
`timescale 1ns/10ps
module bssc_monitor (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic i_below_bat_minus_hys,
	input wire logic i_below_trip,
	input wire logic i_above_bat_plus_hys,
	input wire logic i_above_trip_plus_hys,
	input wire logic i_below_bat,
	input wire logic i_sda_pull,
	input wire logic o_sda_o,
	input wire logic o_sda_oe,
	input wire logic o_serial_en,
	input wire logic o_fout_o,
	input wire logic o_on_battery,
	input wire logic o_bat_draw_en,
	input wire logic o_trip_mon_en
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// One wait state, single-cycle answer
	chk_ready_wait: assert property (i_psel && i_penable && !o_pready
		|=> o_pready) else $error("pready late");
	chk_ready_pulse: assert property (o_pready |=> !o_pready)
		else $error("pready held");
	chk_err_ready: assert property (o_pslverr |-> o_pready)
		else $error("pslverr alone");
	chk_serial_off: assert property (o_on_battery |-> !o_serial_en)
		else $error("serial live on battery");
	chk_sda_gate: assert property (o_sda_oe |-> o_serial_en)
		else $error("sda driven while off");
	chk_sda_release: assert property (!i_sda_pull |=> !o_sda_oe)
		else $error("sda held low");
	// A pull request reaches the pin whenever the serial side is live
	chk_sda_pull: assert property (i_sda_pull |=> (o_sda_oe == o_serial_en))
		else $error("sda pull not passed on");
	chk_sda_low: assert property (o_sda_o == 1'b0)
		else $error("sda driven high");
	chk_fout_low: assert property (o_fout_o == 1'b0)
		else $error("pin driven high");
	chk_seal_draw: assert property (!o_bat_draw_en |-> !o_on_battery)
		else $error("battery used while sealed");
	// Latency: two sync flops, then state and output on one edge
	chk_to_battery: assert property ($rose(o_on_battery) |->
		$past(o_trip_mon_en ? (i_below_bat_minus_hys && i_below_trip)
		: i_below_bat, 3)) else $error("bad switch to battery");
	chk_to_main: assert property ($fell(o_on_battery) |->
		$past(i_above_bat_plus_hys || (o_trip_mon_en &&
		i_above_trip_plus_hys), 3)) else $error("bad return to main");
endmodule

//--- tb/bssc_supply_model.sv
/* Supply comparators seen by the block, from millivolt levels.
   Assumes levels held for many clocks between changes. */
`timescale 1ns/10ps
module bssc_supply_model #(
	parameter int PRES_MV = 1000,
	parameter int TRIP_MV = 2600,
	parameter int BHYS_MV = 50,
	parameter int THYS_MV = 30
) (
	input  wire logic [15:0] i_vdd_mv,
	input  wire logic [15:0] i_vbat_mv,
	output logic             o_main_present,
	output logic             o_below_bmh,
	output logic             o_below_trip,
	output logic             o_above_bph,
	output logic             o_above_tph,
	output logic             o_below_bat
);
	always_comb begin
		o_main_present = i_vdd_mv > PRES_MV;
		o_below_bmh    = i_vdd_mv + BHYS_MV < i_vbat_mv;
		o_below_trip   = i_vdd_mv < TRIP_MV;
		o_above_bph    = i_vdd_mv > i_vbat_mv + BHYS_MV;
		o_above_tph    = i_vdd_mv > TRIP_MV + THYS_MV;
		o_below_bat    = i_vdd_mv < i_vbat_mv;
	end
endmodule

//--- tb/backup_supply_switch_control_tb.sv
/* Self-checking bench for bssc_top.
   Assumes the comparator model and monitor are compiled first. */
`timescale 1ns/10ps
module backup_supply_switch_control_tb;
	logic i_clk = 0, i_rst = 1, psel = 0, pen = 0, pwr = 0;
	logic [9:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata;
	logic pready, pslverr, mp, bmh, bt, bph, tph, bb, alarm = 0;
	logic sda_pull = 0, sda_o, sda_oe, ser, fo, foe, bat, draw, tmon;
	logic trun, irq;
	logic [15:0] vdd = 0, vbat = 3000;
	logic tl = 1, pf;  // Total loss strap, last seen pin level
	logic [32:0] exp_q[$];
	int miscompares = 0, n_checks = 0, tog;
	bssc_supply_model mdl (.i_vdd_mv(vdd), .i_vbat_mv(vbat),
		.o_main_present(mp), .o_below_bmh(bmh), .o_below_trip(bt),
		.o_above_bph(bph), .o_above_tph(tph), .o_below_bat(bb));
	bssc_top #(.FOUT_HALF(4)) uut (.i_clk, .i_rst, .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_main_present(mp),
		.i_below_bat_minus_hys(bmh), .i_below_trip(bt),
		.i_above_bat_plus_hys(bph), .i_above_trip_plus_hys(tph),
		.i_below_bat(bb), .i_alarm_match(alarm), .i_total_loss(tl),
		.i_sda_pull(sda_pull), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
		.o_serial_en(ser), .o_fout_o(fo), .o_fout_oe(foe),
		.o_on_battery(bat), .o_bat_draw_en(draw),
		.o_trip_mon_en(tmon), .o_time_run(trun), .o_irq(irq));
	initial forever #2 i_clk = ~i_clk;
	task check(input logic [32:0] seen, input logic [32:0] e);
		n_checks++;
		if (seen !== e) begin
			miscompares++;
			$display("unexpected at %0t: %h vs %h", $time, seen, e);
		end
	endtask
	task tally_and_finish;
		if (miscompares == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// APB transfer; waits for pready under a bound.
	// One idle edge at the end, so that a following call never drives
	// psel twice in the same time step.
	task apb(input logic w, input logic [7:0] i, input logic [31:0] d,
		input logic [32:0] e);
		int n;
		exp_q.push_back(e);
		psel <= 1;
		pwr <= w;
		paddr <= {i, 2'b00};
		pwdata <= d;
		@(posedge i_clk);
		pen <= 1;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (pready !== 1 && n < 20);
		// Bound used up: count it and close the run
		if (pready !== 1) begin
			miscompares++;
			tally_and_finish;
		end
		psel <= 0;
		pen <= 0;
		@(posedge i_clk);
	endtask
	task wr(input logic [7:0] i, input logic [31:0] d);
		apb(1, i, d, 33'h0);
	endtask
	task rd(input logic [7:0] i, input logic [32:0] e);
		apb(0, i, 32'h0, e);
	endtask
	// Comparator path is three edges; eight gives margin
	task st(input logic [2:0] e);
		repeat (8) @(posedge i_clk);
		check({30'h0, bat, ser, draw}, {30'h0, e});
	endtask
	// Oldest note against each answer
	always @(posedge i_clk) if (pready === 1) begin
		check({pslverr, pwr ? 32'h0 : prdata}, exp_q.pop_front());
	end
	// Random serial pull requests; the seed is given in the process
	// that draws, so that it really reaches the pin
	initial begin
		void'($urandom(32'h5CFC));
		forever begin
			@(posedge i_clk);
			sda_pull <= 1'($urandom % 2);
		end
	end
	// Scenario sequence
	initial begin
		repeat (4) @(posedge i_clk);
		i_rst <= 0;
		st(3'b000);
		check({32'h0, trun}, 33'h0);
		check({32'h0, foe}, 33'h0);
		rd(8'h07, 33'h80);
		rd(8'h0B, 33'h01);
		vdd <= 3300;
		st(3'b011);
		wr(8'h00, 32'h0);
		st(3'b011);
		check({32'h0, trun}, 33'h1);
		wr(8'h0B, 32'h1);
		rd(8'h0B, 33'h0);
		wr(8'h21, 32'h2);
		vdd <= 2800;
		st(3'b011);
		vdd <= 2500;
		st(3'b101);
		check({32'h0, irq}, 33'h1);
		rd(8'h0B, 33'h02);
		vdd <= 2620;
		st(3'b101);
		vdd <= 2640;
		st(3'b011);
		rd(8'h20, 33'h6);
		wr(8'h20, 32'h2);
		st(3'b011);
		check({32'h0, irq}, 33'h0);
		vbat <= 2000;
		vdd <= 1900;
		st(3'b101);
		vdd <= 2060;
		st(3'b011);
		vbat <= 3000;
		vdd <= 3300;
		wr(8'h08, 32'h20);
		st(3'b011);
		check({32'h0, tmon}, 33'h0);
		vdd <= 2990;
		st(3'b101);
		vdd <= 3030;
		st(3'b101);
		vdd <= 3100;
		st(3'b011);
		wr(8'h08, 32'h0);
		wr(8'h0B, 32'h20);
		st(3'b000);
		vdd <= 0;
		st(3'b000);
		vdd <= 3300;
		st(3'b011);
		wr(8'h07, 32'h0);
		st(3'b011);
		check({32'h0, foe}, 33'h1);
		wr(8'h07, 32'h40);
		// Count pin changes edge to edge over a fixed window
		tog = 0;
		pf = foe;
		repeat (32) begin
			@(posedge i_clk);
			if (foe !== pf) begin
				tog++;
			end
			pf = foe;
		end
		check({32'h0, tog >= 7 && tog <= 9}, 33'h1);
		wr(8'h08, 32'h40);
		alarm <= 1;
		@(posedge i_clk);
		alarm <= 0;
		st(3'b011);
		rd(8'h0B, 33'h04);
		rd(8'h20, 33'h7);
		wr(8'h0B, 32'h4);
		rd(8'h0B, 33'h00);
		// Unmapped index answers with an error and zero data
		rd(8'hFF, 33'h100000000);
		// Second power-on, this time without total loss
		tl <= 0;
		i_rst <= 1;
		repeat (4) @(posedge i_clk);
		i_rst <= 0;
		st(3'b011);
		check({32'h0, trun}, 33'h1);
		rd(8'h0B, 33'h00);
		tally_and_finish;
	end
endmodule
bind bssc_top bssc_monitor u_mon (.i_clk, .i_rst, .i_psel, .i_penable,
	.o_pready, .o_pslverr, .i_below_bat_minus_hys, .i_below_trip,
	.i_above_bat_plus_hys, .i_above_trip_plus_hys, .i_below_bat,
	.i_sda_pull, .o_sda_o, .o_sda_oe, .o_serial_en, .o_fout_o,
	.o_on_battery, .o_bat_draw_en, .o_trip_mon_en);
